// ---- logic/itt_engine.v ----
`timescale 1ns/100ps
`include "itt_consts.vh"
// Summary of operation
// - Short mode reaches low and high 8 MB
// - Full mode reaches whole 32-bit space
// - Units are byte, word or longword
// - Block moves 1 to 256 units per activation
// - Activating vector forwarded as processor interrupt
// - Optional interrupt at the end of every activation
// - Interrupt when transfer count is exhausted
// - Event link pulse per transfer or block
// - Read skip reuses held descriptor
// - Fixed addresses are not written back
// - Write-back disable bit suppresses all write-back
// - Optional displacement added to source address
// - Module stop blocks all new activations
// - Repeat reloads start address at repeat size
// - Chaining every time or at count zero
// - First data selects sequence via index table
// - Sequence may pause at end flag, resume
module itt_engine #(
  parameter FIFO_DEPTH = `ITT_FIFO_DEPTH
) (
  input wire sys_clk,
  input wire rstn,
  input wire act_valid,
  input wire [7:0] act_vector,
  output wire act_ready,
  output reg cpu_irq_r,
  output reg [7:0] cpu_irq_vector_r,
  output reg elc_req_r,
  output reg mem_req_r,
  output reg mem_we_r,
  output reg [31:0] mem_addr_r,
  output reg [1:0] mem_size_r,
  output reg [31:0] mem_wdata_r,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire module_stop,
  input wire short_address_mode,
  input wire read_skip_enable,
  input wire [31:0] vector_base,
  input wire [31:0] index_table_base,
  input wire sequence_enable,
  input wire [7:0] sequence_vector,
  input wire [31:0] address_displacement,
  output wire busy,
  output wire stopped
);
  localparam ST_IDLE = 4'h0;
  localparam ST_VEC = 4'h1;
  localparam ST_DESC = 4'h2;
  localparam ST_SET = 4'h3;
  localparam ST_XFER = 4'h4;
  localparam ST_FIN = 4'h5;
  localparam ST_WB = 4'h6;
  localparam ST_NEXT = 4'h7;
  localparam ST_IDX = 4'h8;

  reg [3:0] st_r;
  reg [7:0] mode_a_r;
  reg [7:0] mode_b_r;
  reg [7:0] rsz_r;
  reg [7:0] rem_r;
  reg [31:0] src_r;
  reg [31:0] dst_r;
  reg [15:0] tcnt_r;
  reg [31:0] desc_ptr_r;
  reg [2:0] wcnt_r;
  reg [8:0] rd_left_r;
  reg [8:0] wr_left_r;
  reg [7:0] vec_r;
  reg [7:0] last_vec_r;
  reg last_ok_r;
  reg seq_act_r;
  reg seq_paused_r;
  reg [31:0] seq_resume_r;
  reg first_r;
  reg [7:0] first_data_r;
  reg exh_r;
  reg irq_pend_r;
  reg chained_r;

  function [31:0] itt_step;
    input [31:0] a;
    input [1:0] am;
    input [1:0] sz;
    reg [31:0] inc;
    begin
      inc = 32'h1 << sz;
      if (am == `ITT_AM_INC) begin
        itt_step = a + inc;
      end else if (am == `ITT_AM_DEC) begin
        itt_step = a - inc;
      end else begin
        itt_step = a;
      end
    end
  endfunction

  function [31:0] itt_rewind;
    input [31:0] a;
    input [1:0] am;
    input [1:0] sz;
    input [8:0] n;
    reg [31:0] span;
    begin
      span = {23'h0, n} << sz;
      if (am == `ITT_AM_INC) begin
        itt_rewind = a - span;
      end else if (am == `ITT_AM_DEC) begin
        itt_rewind = a + span;
      end else begin
        itt_rewind = a;
      end
    end
  endfunction

  function [8:0] itt_span;
    input [7:0] size;
    begin
      itt_span = (size == `ITT_RST_BYTE) ? 9'h100 : {1'b0, size};
    end
  endfunction

  function [31:0] itt_mask;
    input [31:0] d;
    input [1:0] sz;
    begin
      case (sz)
        `ITT_SZ_BYTE: itt_mask = {24'h0, d[7:0]};
        `ITT_SZ_WORD: itt_mask = {16'h0, d[15:0]};
        default: itt_mask = d;
      endcase
    end
  endfunction

  wire [1:0] md = mode_a_r[`ITT_MA_MD];
  wire [1:0] sz = mode_a_r[`ITT_MA_SZ];
  wire [1:0] sm = mode_a_r[`ITT_MA_SM];
  wire [1:0] dm = mode_b_r[`ITT_MB_DM];
  wire src_area = mode_b_r[`ITT_MB_SRC_AREA];
  wire [8:0] span = itt_span(rsz_r);
  wire ack = mem_req_r && mem_ack;
  wire seq_hit = sequence_enable && (act_vector == sequence_vector);
  wire [31:0] disp = mode_a_r[`ITT_MA_DISP] ? address_displacement : `ITT_RST_WORD;
  wire [31:0] src_eff = src_r + disp;
  wire [31:0] src_bus;
  wire [31:0] dst_bus;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire can_wr;
  wire can_rd;
  wire fifo_push;
  wire wb_need;
  wire [31:0] chain_ptr = desc_ptr_r + `ITT_DESC_BYTES;

  assign act_ready = (st_r == ST_IDLE) && !module_stop;
  assign busy = (st_r != ST_IDLE);
  assign stopped = module_stop && (st_r == ST_IDLE);
  // Writes drain when reads are done or the buffer is full
  assign can_wr = (st_r == ST_XFER) && !mem_req_r && fifo_out_valid &&
                  ((rd_left_r == 9'h0) || !fifo_in_ready);
  assign can_rd = (st_r == ST_XFER) && !mem_req_r && !can_wr &&
                  (rd_left_r != 9'h0) && fifo_in_ready;
  assign fifo_push = (st_r == ST_XFER) && ack && !mem_we_r;
  assign wb_need = !mode_a_r[`ITT_MA_WB_DIS] &&
                   !((wcnt_r == `ITT_DW_SRC) && (sm == `ITT_AM_FIXED)) &&
                   !((wcnt_r == `ITT_DW_DST) && (dm == `ITT_AM_FIXED));

  itt_addr_map u_src_map (
    .addr_in(src_eff),
    .short_mode(short_address_mode),
    .addr_out(src_bus)
  );

  itt_addr_map u_dst_map (
    .addr_in(dst_r),
    .short_mode(short_address_mode),
    .addr_out(dst_bus)
  );

  itt_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(itt_mask(mem_rdata, sz)),
    .out_valid(fifo_out_valid),
    .out_ready(can_wr),
    .out_data(fifo_out_data)
  );

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      mode_a_r <= `ITT_RST_BYTE;
      mode_b_r <= `ITT_RST_BYTE;
      rsz_r <= `ITT_RST_BYTE;
      rem_r <= `ITT_RST_BYTE;
      src_r <= `ITT_RST_WORD;
      dst_r <= `ITT_RST_WORD;
      tcnt_r <= 16'h0;
      desc_ptr_r <= `ITT_RST_WORD;
      wcnt_r <= 3'h0;
      rd_left_r <= 9'h0;
      wr_left_r <= 9'h0;
      vec_r <= `ITT_RST_BYTE;
      last_vec_r <= `ITT_RST_BYTE;
      last_ok_r <= 1'b0;
      seq_act_r <= 1'b0;
      seq_paused_r <= 1'b0;
      seq_resume_r <= `ITT_RST_WORD;
      first_r <= 1'b0;
      first_data_r <= `ITT_RST_BYTE;
      exh_r <= 1'b0;
      irq_pend_r <= 1'b0;
      chained_r <= 1'b0;
      cpu_irq_r <= 1'b0;
      cpu_irq_vector_r <= `ITT_RST_BYTE;
      elc_req_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= `ITT_RST_WORD;
      mem_size_r <= `ITT_SZ_LONG;
      mem_wdata_r <= `ITT_RST_WORD;
    end else begin
      cpu_irq_r <= 1'b0;
      elc_req_r <= 1'b0;
      if (ack) begin
        mem_req_r <= 1'b0;
      end
      case (st_r)
        ST_IDLE: begin
          if (act_valid && act_ready) begin
            vec_r <= act_vector;
            seq_act_r <= seq_hit;
            irq_pend_r <= 1'b0;
            chained_r <= 1'b0;
            wcnt_r <= 3'h0;
            if (seq_hit && seq_paused_r) begin
              desc_ptr_r <= seq_resume_r;
              st_r <= ST_DESC;
            end else if (read_skip_enable && last_ok_r && !seq_hit &&
                         (act_vector == last_vec_r)) begin
              st_r <= ST_SET;
            end else begin
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b0;
              mem_size_r <= `ITT_SZ_LONG;
              mem_addr_r <= vector_base + {22'h0, act_vector, 2'b00};
              st_r <= ST_VEC;
            end
          end
        end
        ST_VEC: begin
          if (ack) begin
            desc_ptr_r <= mem_rdata;
            st_r <= ST_DESC;
          end
        end
        ST_DESC: begin
          if (ack) begin
            case (wcnt_r)
              `ITT_DW_MODE: begin
                mode_a_r <= mem_rdata[31:24];
                mode_b_r <= mem_rdata[23:16];
                rsz_r <= mem_rdata[15:8];
                rem_r <= mem_rdata[7:0];
              end
              `ITT_DW_SRC: src_r <= mem_rdata;
              `ITT_DW_DST: dst_r <= mem_rdata;
              default: tcnt_r <= mem_rdata[15:0];
            endcase
            wcnt_r <= wcnt_r + 3'h1;
            if (wcnt_r == `ITT_DW_COUNT) begin
              st_r <= ST_SET;
            end
          end else if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b0;
            mem_size_r <= `ITT_SZ_LONG;
            mem_addr_r <= desc_ptr_r + {27'h0, wcnt_r, 2'b00};
          end
        end
        ST_SET: begin
          rd_left_r <= (md == `ITT_MD_BLOCK) ? span : 9'h1;
          wr_left_r <= (md == `ITT_MD_BLOCK) ? span : 9'h1;
          first_r <= 1'b1;
          st_r <= ST_XFER;
        end
        ST_XFER: begin
          if (can_rd) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b0;
            mem_size_r <= sz;
            mem_addr_r <= src_bus;
          end
          if (can_wr) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b1;
            mem_size_r <= sz;
            mem_addr_r <= dst_bus;
            mem_wdata_r <= fifo_out_data;
          end
          if (ack && !mem_we_r) begin
            src_r <= itt_step(src_r, sm, sz);
            rd_left_r <= rd_left_r - 9'h1;
            first_r <= 1'b0;
            if (first_r) begin
              first_data_r <= mem_rdata[7:0];
            end
          end
          if (ack && mem_we_r) begin
            dst_r <= itt_step(dst_r, dm, sz);
            wr_left_r <= wr_left_r - 9'h1;
            if (wr_left_r == 9'h1) begin
              st_r <= ST_FIN;
            end
          end
        end
        ST_FIN: begin
          elc_req_r <= 1'b1;
          wcnt_r <= 3'h0;
          st_r <= ST_WB;
          if (md == `ITT_MD_REPEAT) begin
            exh_r <= 1'b0;
            irq_pend_r <= irq_pend_r | mode_b_r[`ITT_MB_IRQ_EACH];
            if (rem_r == 8'h1) begin
              rem_r <= rsz_r;
              if (src_area) begin
                src_r <= itt_rewind(src_r, sm, sz, span);
              end else begin
                dst_r <= itt_rewind(dst_r, dm, sz, span);
              end
            end else begin
              rem_r <= rem_r - 8'h1;
            end
          end else begin
            tcnt_r <= tcnt_r - 16'h1;
            exh_r <= (tcnt_r == 16'h1);
            irq_pend_r <= irq_pend_r | mode_b_r[`ITT_MB_IRQ_EACH] |
                          (tcnt_r == 16'h1);
            if (md == `ITT_MD_BLOCK) begin
              if (src_area) begin
                src_r <= itt_rewind(src_r, sm, sz, span);
              end else begin
                dst_r <= itt_rewind(dst_r, dm, sz, span);
              end
            end
          end
        end
        ST_WB: begin
          if (ack) begin
            wcnt_r <= wcnt_r + 3'h1;
          end else if (!mem_req_r) begin
            if (wcnt_r == `ITT_DESC_WORDS) begin
              st_r <= ST_NEXT;
            end else if (wb_need) begin
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b1;
              mem_size_r <= `ITT_SZ_LONG;
              mem_addr_r <= desc_ptr_r + {27'h0, wcnt_r, 2'b00};
              case (wcnt_r)
                `ITT_DW_MODE: mem_wdata_r <= {mode_a_r, mode_b_r, rsz_r, rem_r};
                `ITT_DW_SRC: mem_wdata_r <= src_r;
                `ITT_DW_DST: mem_wdata_r <= dst_r;
                default: mem_wdata_r <= {16'h0, tcnt_r};
              endcase
            end else begin
              wcnt_r <= wcnt_r + 3'h1;
            end
          end
        end
        ST_NEXT: begin
          wcnt_r <= 3'h0;
          if (seq_act_r && mode_b_r[`ITT_MB_IDX_SEL]) begin
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b0;
            mem_size_r <= `ITT_SZ_LONG;
            mem_addr_r <= index_table_base + {22'h0, first_data_r, 2'b00};
            chained_r <= 1'b1;
            st_r <= ST_IDX;
          end else if (mode_b_r[`ITT_MB_CHAIN] &&
                       !(seq_act_r && mode_b_r[`ITT_MB_SEQ_END]) &&
                       (!mode_b_r[`ITT_MB_CHAIN_ZERO] || exh_r)) begin
            desc_ptr_r <= chain_ptr;
            chained_r <= 1'b1;
            st_r <= ST_DESC;
          end else begin
            if (seq_act_r) begin
              seq_paused_r <= mode_b_r[`ITT_MB_SEQ_END] && mode_b_r[`ITT_MB_CHAIN];
              seq_resume_r <= chain_ptr;
            end
            cpu_irq_r <= irq_pend_r;
            cpu_irq_vector_r <= vec_r;
            last_vec_r <= vec_r;
            last_ok_r <= !chained_r && !seq_act_r;
            st_r <= ST_IDLE;
          end
        end
        ST_IDX: begin
          if (ack) begin
            desc_ptr_r <= mem_rdata;
            st_r <= ST_DESC;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- logic/itt_consts.vh ----
`ifndef ITT_CONSTS_VH
`define ITT_CONSTS_VH
// Mode word A fields
`define ITT_MA_MD 7:6
`define ITT_MA_SZ 5:4
`define ITT_MA_SM 3:2
`define ITT_MA_WB_DIS 1
`define ITT_MA_DISP 0
// Mode word B fields
`define ITT_MB_CHAIN 7
`define ITT_MB_CHAIN_ZERO 6
`define ITT_MB_IRQ_EACH 5
`define ITT_MB_SRC_AREA 4
`define ITT_MB_DM 3:2
`define ITT_MB_SEQ_END 1
`define ITT_MB_IDX_SEL 0
// Transfer modes
`define ITT_MD_NORMAL 2'h0
`define ITT_MD_REPEAT 2'h1
`define ITT_MD_BLOCK 2'h2
// Unit sizes
`define ITT_SZ_BYTE 2'h0
`define ITT_SZ_WORD 2'h1
`define ITT_SZ_LONG 2'h2
// Address stepping modes
`define ITT_AM_FIXED 2'h0
`define ITT_AM_INC 2'h2
`define ITT_AM_DEC 2'h3
// Descriptor layout, word index
`define ITT_DW_MODE 3'h0
`define ITT_DW_SRC 3'h1
`define ITT_DW_DST 3'h2
`define ITT_DW_COUNT 3'h3
`define ITT_DESC_WORDS 3'h4
`define ITT_DESC_BYTES 32'h10
// Buffer depth in units
`define ITT_FIFO_DEPTH 32
// Reset values
`define ITT_RST_WORD 32'h0
`define ITT_RST_BYTE 8'h0
`endif

// ---- logic/itt_fifo.v ----
`timescale 1ns/100ps
module itt_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32
) (
  input wire sys_clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] fill_r;
  wire push;
  wire pop;

  assign in_ready = (fill_r != DEPTH[AW:0]);
  assign out_valid = (fill_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      fill_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        fill_r <= fill_r + 1'b1;
      end else if (pop && !push) begin
        fill_r <= fill_r - 1'b1;
      end
    end
  end
endmodule

// ---- logic/itt_addr_map.v ----
`timescale 1ns/100ps
module itt_addr_map (
  input wire [31:0] addr_in,
  input wire short_mode,
  output wire [31:0] addr_out
);
  // Short mode sign-extends bit 23: low and high 8 MB windows
  assign addr_out = short_mode ? {{8{addr_in[23]}}, addr_in[23:0]} : addr_in;
endmodule

// ---- test/itt_mem_model.sv ----
`timescale 1ns/100ps
// Memory on the far side of the transfer bus, with a settable wait
module itt_mem_model (
  input logic sys_clk,
  input logic mem_req_r,
  input logic mem_we_r,
  input logic [31:0] mem_addr_r,
  input logic [1:0] mem_size_r,
  input logic [31:0] mem_wdata_r,
  input logic [3:0] wait_cyc,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  bit [7:0] m [bit [31:0]];
  int n_wr = 0;
  int n_rd = 0;
  int cnt = 0;
  int nb;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  always @(posedge sys_clk) begin
    nb = 1 << mem_size_r;
    mem_ack <= 1'b0;
    // Read data is not held outside the ack cycle
    mem_rdata <= ~mem_rdata;
    if (mem_req_r && !mem_ack) begin
      if (cnt < wait_cyc) cnt++;
      else begin
        cnt = 0;
        mem_ack <= 1'b1;
        if (mem_we_r) begin
          for (int i = 0; i < nb; i++) m[mem_addr_r + i] = mem_wdata_r[8*i +: 8];
          n_wr++;
        end else begin
          for (int i = 0; i < 4; i++) mem_rdata[8*i +: 8] <= i < nb ? m[mem_addr_r + i] : 8'h0;
          n_rd++;
        end
      end
    end
  end
endmodule

// ---- test/itt_engine_assertions.sv ----
`timescale 1ns/100ps
module itt_engine_assertions #(
  parameter FIFO_DEPTH = 32
) (
  input logic sys_clk,
  input logic rstn,
  input logic act_valid,
  input logic [7:0] act_vector,
  input logic act_ready,
  input logic cpu_irq_r,
  input logic elc_req_r,
  input logic mem_req_r,
  input logic mem_we_r,
  input logic [31:0] mem_addr_r,
  input logic [1:0] mem_size_r,
  input logic [31:0] mem_wdata_r,
  input logic mem_ack,
  input logic module_stop,
  input logic short_address_mode,
  input logic read_skip_enable,
  input logic [31:0] vector_base,
  input logic sequence_enable,
  input logic busy,
  input logic stopped
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_hold;
    mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r)
      && $stable(mem_size_r) && $stable(mem_wdata_r);
  endproperty
  a_hold: assert property (p_hold) else $error("bus request changed");
  property p_drop;
    mem_req_r && mem_ack |=> !mem_req_r;
  endproperty
  a_drop: assert property (p_drop) else $error("request kept after ack");
  property p_take;
    act_valid && act_ready |=> busy && !act_ready;
  endproperty
  a_take: assert property (p_take) else $error("activation not taken");
  property p_ready;
    act_ready == (!busy && !module_stop);
  endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_stop;
    module_stop && !busy |=> !busy;
  endproperty
  a_stop: assert property (p_stop) else $error("started while stopped");
  property p_stopped;
    stopped == (module_stop && !busy);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped wrong");
  property p_irq;
    cpu_irq_r |-> !busy ##1 !cpu_irq_r;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not at end");
  property p_elc;
    elc_req_r |-> busy ##1 !elc_req_r;
  endproperty
  a_elc: assert property (p_elc) else $error("event pulse wrong");
  property p_vec;
    act_valid && act_ready && !read_skip_enable && !short_address_mode && !sequence_enable
      |=> mem_req_r
      && !mem_we_r && mem_addr_r == vector_base + {22'h0, $past(act_vector), 2'h0};
  endproperty
  a_vec: assert property (p_vec) else $error("vector fetch wrong");
  property p_size;
    mem_req_r |-> mem_size_r != 2'h3;
  endproperty
  a_size: assert property (p_size) else $error("bad unit size");
  c_take: cover property (act_valid && act_ready);
  c_irq: cover property (cpu_irq_r);
  c_wr: cover property (mem_req_r && mem_we_r && mem_ack);
  c_stop: cover property (module_stop && act_valid && !act_ready);
endmodule

// ---- test/itt_engine_tb.sv ----
`timescale 1ns/100ps
module itt_engine_tb;
  logic sys_clk, rstn, act_valid, act_ready, cpu_irq_r, elc_req_r, busy, stopped;
  logic mem_req_r, mem_we_r, mem_ack, module_stop, short_address_mode, read_skip_enable;
  logic sequence_enable;
  logic [7:0] act_vector, cpu_irq_vector_r, sequence_vector;
  logic [1:0] mem_size_r;
  logic [3:0] wait_cyc;
  logic [31:0] mem_addr_r, mem_wdata_r, mem_rdata, vector_base, address_displacement, msk;
  int n_mismatch = 0;
  int check_count = 0;
  int n_irq, n_elc, w0, r0;
  itt_engine #(.FIFO_DEPTH(32)) dut (
    .sys_clk, .rstn, .act_valid, .act_vector, .act_ready, .cpu_irq_r, .cpu_irq_vector_r,
    .elc_req_r, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_size_r, .mem_wdata_r, .mem_ack,
    .mem_rdata, .module_stop, .short_address_mode, .read_skip_enable, .vector_base,
    .index_table_base(32'h800), .sequence_enable, .sequence_vector,
    .address_displacement, .busy, .stopped
  );
  itt_mem_model mem (
    .sys_clk, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_size_r, .mem_wdata_r, .wait_cyc,
    .mem_ack, .mem_rdata
  );
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task put(input logic [31:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) mem.m[a + i] = d[8*i +: 8];
  endtask
  function automatic logic [31:0] get(input logic [31:0] a);
    return {mem.m[a + 3], mem.m[a + 2], mem.m[a + 1], mem.m[a]};
  endfunction
  function automatic logic [31:0] dp(input logic [7:0] v);
    return 32'h2000 + {v, 4'h0};
  endfunction
  // Vector table entry and descriptor, placed before activation
  task setup(input logic [7:0] v, input logic [31:0] w, s, d, c);
    put(vector_base + {v, 2'h0}, dp(v));
    put(dp(v), w);
    put(dp(v) + 4, s);
    put(dp(v) + 8, d);
    put(dp(v) + 12, c);
  endtask
  task act(input logic [7:0] v);
    int k;
    n_irq = 0;
    n_elc = 0;
    w0 = mem.n_wr;
    r0 = mem.n_rd;
    act_valid <= 1'h1;
    act_vector <= v;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (act_ready !== 1'h1 && k < 50);
    if (k >= 50) k = 20000;
    act_valid <= 1'h0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (busy !== 1'h0 && k < 20000);
    if (k >= 20000) begin
      n_mismatch++;
      report_and_stop;
    end
    // Let the pulse counters see the closing edge
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (cpu_irq_r === 1'h1) n_irq++;
    if (elc_req_r === 1'h1) n_elc++;
  end
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rstn = 1'h0;
    act_valid = 1'h0;
    act_vector = 8'h0;
    module_stop = 1'h0;
    short_address_mode = 1'h0;
    read_skip_enable = 1'h0;
    sequence_enable = 1'h0;
    sequence_vector = 8'h09;
    vector_base = 32'h1000;
    address_displacement = 32'h40;
    wait_cyc = 4'h0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'h1;
    put(32'h3000, 32'h11223344);
    put(32'h3004, 32'h55667788);
    setup(8'h01, 32'h2808_0000, 32'h3000, 32'h3100, 32'h2);
    act(8'h01);
    chk(get(32'h3100), 32'h11223344);
    chk(n_irq, 32'h0);
    chk(n_elc, 32'h1);
    chk(get(dp(8'h01) + 4), 32'h3004);
    chk(get(dp(8'h01) + 12), 32'h1);
    act(8'h01);
    chk(get(32'h3104), 32'h55667788);
    chk(n_irq, 32'h1);
    chk(cpu_irq_vector_r, 32'h1);
    put(32'h3010, 32'ha1b2c3d4);
    for (int i = 0; i < 3; i++) begin
      put(32'h3200, 32'hffff_ffff);
      setup(8'h02, {2'h0, i[1:0], 4'h2, 24'h0}, 32'h3010, 32'h3200, 32'h5);
      msk = i == 0 ? 32'hff : i == 1 ? 32'hffff : 32'hffff_ffff;
      act(8'h02);
      chk(get(32'h3200), ~msk | 32'ha1b2c3d4 & msk);
      chk(mem.n_wr - w0, 32'h1);
      chk(get(dp(8'h02) + 12), 32'h5);
    end
    put(32'h3060, 32'hcafe_0001);
    setup(8'h03, 32'h2120_0000, 32'h3020, 32'h3120, 32'h5);
    act(8'h03);
    chk(get(32'h3120), 32'hcafe_0001);
    chk(n_irq, 32'h1);
    chk(mem.n_wr - w0, 32'h3);
    put(32'h00f00010, 32'hf00d);
    put(32'hfff00010, 32'hbeef);
    setup(8'h06, 32'h2000_0000, 32'h00f00010, 32'h3300, 32'h5);
    for (int i = 0; i < 2; i++) begin
      short_address_mode <= i[0];
      act(8'h06);
      chk(get(32'h3300), i ? 32'hbeef : 32'hf00d);
    end
    short_address_mode <= 1'h0;
    put(32'h3400, 32'ha0);
    put(32'h3404, 32'ha1);
    setup(8'h07, 32'h6810_0202, 32'h3400, 32'h3500, 32'h9);
    for (int i = 0; i < 3; i++) begin
      act(8'h07);
      chk(get(32'h3500), i == 1 ? 32'ha1 : 32'ha0);
    end
    read_skip_enable <= 1'h1;
    act(8'h07);
    act(8'h07);
    chk(get(32'h3500), 32'ha0);
    chk(mem.n_rd - r0, 32'h1);
    read_skip_enable <= 1'h0;
    put(32'h3a00, 32'h0);
    setup(8'h0b, 32'h2808_0000, 32'h3004, 32'h3a00, 32'h5);
    setup(8'h0a, 32'h28c8_0000, 32'h3000, 32'h3a04, 32'h2);
    for (int i = 0; i < 2; i++) begin
      act(8'h0a);
      chk(get(32'h3a00), i ? 32'h55667788 : 32'h0);
      chk(n_elc, i + 1);
    end
    put(32'h3600, 32'h2);
    put(32'h808, 32'h2400);
    setup(8'h09, 32'h0a09_0000, 32'h3600, 32'h3700, 32'h5);
    setup(8'h40, 32'h288a_0000, 32'h3000, 32'h3800, 32'h5);
    setup(8'h41, 32'h2808_0000, 32'h3004, 32'h3900, 32'h5);
    sequence_enable <= 1'h1;
    act(8'h09);
    chk(mem.m[32'h3700], 32'h2);
    chk(get(32'h3800), 32'h11223344);
    act(8'h09);
    chk(get(32'h3900), 32'h55667788);
    chk(mem.n_rd - r0, 32'h5);
    sequence_enable <= 1'h0;
    for (int k = 0; k < 256; k++) mem.m[32'h4000 + k] = k[7:0];
    mem.m[32'h5100] = 8'hee;
    wait_cyc <= 4'h3;
    setup(8'h08, 32'h8808_0000, 32'h4000, 32'h5000, 32'h1);
    act(8'h08);
    for (int k = 0; k < 256; k++) chk(mem.m[32'h5000 + k], k[7:0]);
    chk(mem.m[32'h5100], 32'hee);
    chk(n_elc, 32'h1);
    chk(n_irq, 32'h1);
    wait_cyc <= 4'h0;
    module_stop <= 1'h1;
    act_valid <= 1'h1;
    r0 = mem.n_rd;
    repeat (4) @(posedge sys_clk);
    chk(act_ready, 32'h0);
    chk(stopped, 32'h1);
    chk(busy, 32'h0);
    chk(mem.n_rd - r0, 32'h0);
    module_stop <= 1'h0;
    act(8'h06);
    chk(n_elc, 32'h1);
    chk(get(32'h3300), 32'hf00d);
    report_and_stop;
  end
endmodule
bind itt_engine itt_engine_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .sys_clk, .rstn, .act_valid, .act_vector, .act_ready, .cpu_irq_r, .elc_req_r, .mem_req_r,
  .mem_we_r, .mem_addr_r, .mem_size_r, .mem_wdata_r, .mem_ack, .module_stop,
  .short_address_mode, .read_skip_enable, .vector_base, .sequence_enable, .busy, .stopped
);
